// ===== accs_pkg.sv
/*
 Constants for the converter start and initialization control block.
 Assumes one 250 MHz core clock and an active-low asynchronous reset.
*/
package accs_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // Conversion time in ns, a plain default
   localparam int unsigned CONV_TIME_NS = 400;
   localparam int unsigned CONV_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
   // Fast initialization after a reset pulse, in ns
   localparam int unsigned INIT_TIME_NS = 100;
   localparam int unsigned INIT_CYC = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DISCARD_CONV = 128;
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] CONV_CNT = CNT_W'(CONV_CYC);
   localparam logic [CNT_W-1:0] INIT_CNT = CNT_W'(INIT_CYC);
   localparam logic [CNT_W-1:0] DISC_CNT = CNT_W'(DISCARD_CONV);
   localparam logic [2:0] SYNC_RST = 3'h7;
   typedef enum logic [1:0]
   {
      ACCS_IDLE = 2'h0,
      ACCS_CONV = 2'h1,
      ACCS_INIT = 2'h3,
      ACCS_HIZ = 2'h2
   } accs_state_t;
endpackage

// ===== accs_ctrl.sv
/*
 Converter start, protection, initialization and reference select control.
 Assumes the host drives start, reset and static pins asynchronously;
 every pin passes a three-stage synchroniser before use.
*/
// Contract
// - Start falling edge launches a conversion
// - Running conversion ignores starts and sleep
// - Chip select and read never gate start
// - Power-up or wake flags first 128 conversions
// - Interface stays enabled in acquisition too
// - Both low enables bandgap and buffer
// - Reference high only: bandgap off, buffer on
// - Both high disables bandgap and buffer
// - Reset rise aborts conversion, floats bus
// - Reset fall clears bus, pulses busy
module accs_ctrl
   import accs_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic convert_start_n,
   input wire logic conv_reset,
   input wire logic sleep_request,
   input wire logic reference_powerdown,
   input wire logic buffer_powerdown,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   output logic busy,
   output logic bandgap_en,
   output logic refbuf_en,
   output logic bus_hiz,
   output logic bus_clear,
   output logic iface_en,
   output logic discard_result,
   output logic conv_done
);
   import accs_pkg::*;

   typedef struct packed {
      logic [2:0] st_s;
      logic [2:0] rs_s;
      logic [2:0] sl_s;
      logic [2:0] pr_s;
      logic [2:0] pb_s;
      logic st_l;
      logic rs_l;
      logic sl_l;
      accs_state_t fsm;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] disc;
      logic busy;
      logic bg;
      logic buf_en;
      logic hiz;
      logic clr;
      logic done;
      logic iface;
      logic discard;
   } accs_reg_t;

   accs_reg_t r_q;
   accs_reg_t r_d;

   // Agreed level of a three-stage synchroniser, else previous level
   function automatic logic settle(input logic [2:0] s, input logic prev);
      settle = (s[1] == s[2]) ? s[2] : prev;
   endfunction

   // One-step count down, shared by both timers and the discard count
   function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
      dec = v - CNT_W'(1);
   endfunction

   logic st_n;
   logic rs_n;
   logic sl_n;
   logic pr_n;
   logic pb_n;

   always_comb
   begin
      r_d = r_q;
      r_d.st_s = {r_q.st_s[1:0], convert_start_n};
      r_d.rs_s = {r_q.rs_s[1:0], conv_reset};
      r_d.sl_s = {r_q.sl_s[1:0], sleep_request};
      r_d.pr_s = {r_q.pr_s[1:0], reference_powerdown};
      r_d.pb_s = {r_q.pb_s[1:0], buffer_powerdown};
      st_n = settle(r_q.st_s, r_q.st_l);
      rs_n = settle(r_q.rs_s, r_q.rs_l);
      sl_n = settle(r_q.sl_s, r_q.sl_l);
      pr_n = settle(r_q.pr_s, !r_q.bg);
      pb_n = settle(r_q.pb_s, !r_q.buf_en);
      r_d.st_l = st_n;
      r_d.rs_l = rs_n;
      r_d.sl_l = sl_n;
      r_d.done = 1'b0;
      r_d.clr = 1'b0;
      // Reference modes; both-high and ref-only differ only in buffer
      r_d.bg = !pr_n;
      r_d.buf_en = !pb_n;
      case (r_q.fsm)
         ACCS_IDLE:
         begin
            r_d.busy = 1'b0;
            // Select and read strobe deliberately not examined
            if (r_q.st_l && !st_n)
            begin
               r_d.fsm = ACCS_CONV;
               r_d.cnt = CONV_CNT;
               r_d.busy = 1'b1;
               r_d.hiz = 1'b0;
            end
         end
         ACCS_CONV:
         begin
            // Start edges and sleep are not looked at here
            if (r_q.cnt == CNT_W'(1))
            begin
               r_d.fsm = ACCS_IDLE;
               r_d.busy = 1'b0;
               r_d.done = 1'b1;
               if (r_q.disc != '0)
               begin
                  r_d.disc = dec(r_q.disc);
               end
            end
            else
            begin
               r_d.cnt = dec(r_q.cnt);
            end
         end
         ACCS_HIZ:
         begin
            r_d.busy = 1'b0;
            if (r_q.rs_l && !rs_n)
            begin
               r_d.fsm = ACCS_INIT;
               r_d.cnt = INIT_CNT;
               r_d.clr = 1'b1;
               r_d.hiz = 1'b0;
               r_d.busy = 1'b1;
            end
         end
         ACCS_INIT:
         begin
            if (r_q.cnt == CNT_W'(1))
            begin
               r_d.fsm = ACCS_IDLE;
               r_d.busy = 1'b0;
               r_d.disc = '0;
            end
            else
            begin
               r_d.cnt = dec(r_q.cnt);
            end
         end
         default:
         begin
            r_d.fsm = ACCS_IDLE;
            r_d.busy = 1'b0;
         end
      endcase
      // Leaving sleep restarts the slow initialization window
      // Reload wins over a same-cycle decrement or init clear
      if (r_q.sl_l && !sl_n)
      begin
         r_d.disc = DISC_CNT;
      end
      // Reset rise overrides state, busy, done and bus float, even a running conversion; discard count and reference enables untouched
      if (!r_q.rs_l && rs_n)
      begin
         r_d.fsm = ACCS_HIZ;
         r_d.busy = 1'b0;
         r_d.done = 1'b0;
         r_d.hiz = 1'b1;
      end
      // Registered copies so both outputs leave a flip-flop
      r_d.iface = !r_d.hiz;
      r_d.discard = (r_d.disc != '0);
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         r_q <= '0;
         r_q.st_s <= SYNC_RST;
         r_q.st_l <= 1'b1;
         r_q.fsm <= ACCS_IDLE;
         r_q.disc <= DISC_CNT;
         r_q.bg <= 1'b1;
         r_q.buf_en <= 1'b1;
         r_q.iface <= 1'b1;
         r_q.discard <= 1'b1;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign busy = r_q.busy;
   assign bandgap_en = r_q.bg;
   assign refbuf_en = r_q.buf_en;
   assign bus_hiz = r_q.hiz;
   assign bus_clear = r_q.clr;
   // Interface never gated by phase; only reset floats it
   assign iface_en = r_q.iface;
   assign discard_result = r_q.discard;
   assign conv_done = r_q.done;

   AST_START_BUSY: assert property (@(posedge core_clk) disable iff (!resetn)
      (r_q.fsm == ACCS_IDLE && r_q.st_l && !st_n && !(!r_q.rs_l && rs_n))
      |=> busy) else $error("start edge did not raise busy");
   AST_NO_ABORT: assert property (@(posedge core_clk) disable iff (!resetn)
      (r_q.fsm == ACCS_CONV && r_q.cnt > CNT_W'(1) && !(!r_q.rs_l && rs_n))
      |=> r_q.fsm == ACCS_CONV) else $error("conversion cut short");
   AST_BUSY_LEN: assert property (@(posedge core_clk) disable iff (!resetn)
      ($rose(busy) && r_q.fsm == ACCS_CONV && r_q.cnt == CONV_CNT)
      |-> busy [*2]) else $error("busy too short");
   AST_RST_ABORT: assert property (@(posedge core_clk) disable iff (!resetn)
      (!r_q.rs_l && rs_n) |=> (bus_hiz && !busy))
      else $error("reset rise did not float bus");
   AST_RST_FALL: assert property (@(posedge core_clk) disable iff (!resetn)
      (r_q.fsm == ACCS_HIZ && r_q.rs_l && !rs_n)
      |=> (bus_clear && busy && !bus_hiz))
      else $error("reset fall did not start init");
   AST_REF_INT: assert property (@(posedge core_clk) disable iff (!resetn)
      (!pr_n && !pb_n) |=> (bandgap_en && refbuf_en))
      else $error("internal reference not enabled");
   AST_REF_EXTBUF: assert property (@(posedge core_clk) disable iff (!resetn)
      (pr_n && !pb_n) |=> (!bandgap_en && refbuf_en))
      else $error("external buffered reference wrong");
   AST_REF_EXT: assert property (@(posedge core_clk) disable iff (!resetn)
      (pr_n && pb_n) |=> (!bandgap_en && !refbuf_en))
      else $error("external direct reference wrong");
   AST_WAKE: assert property (@(posedge core_clk) disable iff (!resetn)
      (r_q.sl_l && !sl_n) |=> discard_result)
      else $error("wake did not flag discard");
endmodule

// ===== accs_host.sv
/*
 Host model that drives the converter start and reset pins.
 Assumes the bench calls its tasks just after a falling clock edge.
*/
module accs_host
(
   output logic convert_start_n,
   output logic conv_reset
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bench returns start high well inside the conversion
   task set_start(input logic v);
      convert_start_n = v;
   endtask
   // Pulse used instead of discarding early results
   task set_reset(input logic v);
      conv_reset = v;
   endtask
endmodule

// ===== test_adc_conversion_start_and_init_control.sv
/*
 Self-checking bench for the start and initialization control.
 Assumes the host model drives start and reset; bench drives the rest.
*/
module test_adc_conversion_start_and_init_control;
   import accs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, sleep_request;
   logic reference_powerdown, buffer_powerdown;
   logic chip_select_n, read_strobe_n;
   logic convert_start_n, conv_reset, busy, bandgap_en, refbuf_en;
   logic bus_hiz, bus_clear, iface_en, discard_result, conv_done;
   int fail_count = 0, compares = 0, cyc, left;
   always #2 core_clk = ~core_clk;
   accs_host host (.convert_start_n, .conv_reset);
   accs_ctrl dut (.core_clk, .resetn, .convert_start_n, .conv_reset,
      .sleep_request, .reference_powerdown, .buffer_powerdown,
      .chip_select_n, .read_strobe_n, .busy, .bandgap_en, .refbuf_en,
      .bus_hiz, .bus_clear, .iface_en, .discard_result, .conv_done);
   task chk(input logic a, input logic e);
      compares++;
      if (a !== e)
      begin
         fail_count++;
         $display("BAD %0t output differs from model", $time);
      end
   endtask
   task tick(input int k);
      repeat (k) @(negedge core_clk);
      cyc += k;
   endtask
   task end_of_test;
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Random control levels prove chip select and read never gate start
   task conv(input bit mid);
      chip_select_n = 1'($urandom);
      read_strobe_n = 1'($urandom);
      host.set_start(1'b0);
      cyc = 0;
      while (!busy && cyc < 10) tick(1);
      chk(busy, 1'b1);
      chk(iface_en, 1'b1);
      cyc = 0;
      tick($urandom_range(1, 20));
      host.set_start(1'b1);
      if (mid)
      begin
         sleep_request = 1'b1;
         tick(5);
         host.set_start(1'b0);
         tick(5);
         host.set_start(1'b1);
      end
      while (!conv_done && cyc < 300) tick(1);
      chk(cyc == CONV_CYC, 1'b1);
      chk(busy, 1'b0);
      sleep_request = 1'b0;
      tick(8);
   endtask
   initial
   begin
      // Whole run is about 15000 cycles; reaching 40000 means a hang
      repeat (40000) @(negedge core_clk);
      fail_count++;
      end_of_test();
   end
   initial
   begin
      core_clk = 1'b0;
      resetn = 1'b0;
      sleep_request = 1'b0;
      reference_powerdown = 1'b0;
      buffer_powerdown = 1'b0;
      host.set_start(1'b1);
      host.set_reset(1'b0);
      void'($urandom(32'hB7FB));
      chip_select_n = 1'($urandom);
      read_strobe_n = 1'($urandom);
      tick(20);
      resetn = 1'b1;
      tick(5);
      chk(discard_result, 1'b1);
      for (int i = 0; i < 3; i++)
      begin
         reference_powerdown = (i > 0);
         buffer_powerdown = (i > 1);
         tick(6);
         chk(bandgap_en, i == 0);
         chk(refbuf_en, i < 2);
      end
      conv(1'b1);
      left = 128;
      chk(discard_result, 1'b1);
      for (int i = 0; i < 128; i++)
      begin
         conv(1'b0);
         left--;
         chk(discard_result, left > 0);
      end
      sleep_request = 1'b1;
      tick(3);
      sleep_request = 1'b0;
      tick(8);
      chk(discard_result, 1'b1);
      host.set_start(1'b0);
      tick(8);
      host.set_reset(1'b1);
      tick(8);
      chk(bus_hiz, 1'b1);
      chk(busy, 1'b0);
      chk(iface_en, 1'b0);
      host.set_start(1'b1);
      host.set_reset(1'b0);
      cyc = 0;
      while (!bus_clear && cyc < 10) tick(1);
      chk(bus_clear, 1'b1);
      chk(busy, 1'b1);
      cyc = 0;
      while (busy && cyc < 100) tick(1);
      chk(cyc == INIT_CYC, 1'b1);
      chk(discard_result, 1'b0);
      // Core reset in mid conversion, start held high across release
      host.set_start(1'b0);
      tick(6);
      chk(busy, 1'b1);
      resetn = 1'b0;
      tick(2);
      chk(busy, 1'b0);
      chk(discard_result, 1'b1);
      host.set_start(1'b1);
      tick(3);
      resetn = 1'b1;
      tick(6);
      chk(busy, 1'b0);
      chk(bandgap_en, 1'b0);
      chk(refbuf_en, 1'b0);
      chk(discard_result, 1'b1);
      conv(1'b0);
      end_of_test();
   end
endmodule
